// ### core/sfcs_top.sv
`timescale 1ns/100ps
module sfcs_top
   import sfcs_pkg::*;
#(
   parameter bit ZERO_IN_SUPPORTED = 1'b1
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic op_valid,
   input wire sfcs_op_type op_kind,
   input wire logic [31:0] op_wdata,
   input wire logic [3:0] op_addr_lo,
   output logic op_done,
   output logic op_fault,
   output logic [31:0] op_rdata,
   input wire logic ar_valid,
   input wire logic [5:0] ar_cond,
   input wire logic [31:0] ar_src,
   input wire logic [31:0] ar_res,
   output logic ar_done,
   output logic ar_exc,
   output logic [31:0] ar_operand,
   output logic [31:0] ar_result,
   output logic [1:0] rounding_mode_field,
   output logic flush_tiny_results,
   output logic subnormal_input_zeroing,
   output logic [5:0] exc_flags,
   output logic [5:0] exc_masks
);

   localparam logic [31:0] SUPPORTED_BITS_MASK =
      ZERO_IN_SUPPORTED ? SFCS_SUPPORT_ALL : SFCS_SUPPORT_NO_ZERO_IN;
   localparam logic [3:0] ALIGN_MASK = 4'(SFCS_PACKED_ALIGN - 1);

   sfcs_state_type st_ff;
   sfcs_state_type nxt_st;
   logic is_ld;
   logic ld_bad;
   logic ld_ok;
   logic misaligned;
   logic src_subnormal;
   logic ftz;
   logic [5:0] cond_eff;
   logic [5:0] set_flags;
   logic [31:0] csr_word;

   // refuse a layout that the fixed slices and the 4-bit address cannot serve
   if (SFCS_NUM_EXC != 6 || SFCS_SCALAR_BYTES != 4 ||
       SFCS_PACKED_ALIGN > 16) begin : g_bad_layout
      $error("sfcs_top: unsupported field layout");
   end

   always_comb begin
      // assembled word, reserved bits always zero
      csr_word = {SFCS_RSV_RST, st_ff.flush, st_ff.round, st_ff.masks,
                  st_ff.zero_in, st_ff.flags};
      nxt_st = st_ff;
      nxt_st.op_done = 1'b0;
      nxt_st.op_fault = 1'b0;
      nxt_st.ar_done = 1'b0;
      nxt_st.ar_exc = 1'b0;

      // word loads
      is_ld = op_valid &&
              (op_kind == SFCS_OP_LOAD || op_kind == SFCS_OP_RESTORE);
      ld_bad = |(op_wdata & ~SUPPORTED_BITS_MASK);
      ld_ok = is_ld && !ld_bad;
      misaligned = op_valid && op_kind == SFCS_OP_PACKED_MEM &&
                   |(op_addr_lo & ALIGN_MASK);
      if (op_valid) begin
         nxt_st.op_done = 1'b1;
         nxt_st.op_fault = (is_ld && ld_bad) || misaligned;
      end
      if (op_valid &&
          (op_kind == SFCS_OP_STORE || op_kind == SFCS_OP_SAVE)) begin
         nxt_st.op_rdata = csr_word;
      end
      if (ld_ok) begin
         nxt_st.zero_in = op_wdata[SFCS_ZERO_IN_BIT];
         nxt_st.masks = op_wdata[SFCS_MASK_LSB +: 6];
         nxt_st.round = op_wdata[SFCS_ROUND_LSB +: 2];
         nxt_st.flush = op_wdata[SFCS_FLUSH_BIT];
      end

      // arithmetic event handling with current modes
      src_subnormal = ar_src[30:23] == 8'h00 && ar_src[22:0] != 23'h0;
      cond_eff = ar_cond;
      if (st_ff.zero_in) begin
         cond_eff[SFCS_EX_DEN] = 1'b0;
      end
      ftz = cond_eff[SFCS_EX_UNF] && st_ff.masks[SFCS_EX_UNF] &&
            st_ff.flush;
      if (ftz) begin
         cond_eff[SFCS_EX_PRE] = 1'b1;
      end
      set_flags = ar_valid ? cond_eff : 6'h00;
      if (ar_valid) begin
         nxt_st.ar_done = 1'b1;
         nxt_st.ar_exc = |(cond_eff & ~st_ff.masks);
         nxt_st.ar_operand = (st_ff.zero_in && src_subnormal) ?
                             {ar_src[31], 31'h0} : ar_src;
         nxt_st.ar_result = ftz ? {ar_res[31], 31'h0} : ar_res;
      end

      // set wins over the clear of a simultaneous load
      nxt_st.flags = (ld_ok ? op_wdata[SFCS_FLAG_LSB +: 6] : st_ff.flags)
                     | set_flags;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_ff <= '{flags: SFCS_FLAGS_RST,
                    zero_in: SFCS_ZERO_IN_RST,
                    masks: SFCS_MASKS_RST,
                    round: SFCS_ROUND_RST,
                    flush: SFCS_FLUSH_RST,
                    op_done: 1'b0,
                    op_fault: 1'b0,
                    op_rdata: 32'h0,
                    ar_done: 1'b0,
                    ar_exc: 1'b0,
                    ar_operand: 32'h0,
                    ar_result: 32'h0};
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign op_done = st_ff.op_done;
   assign op_fault = st_ff.op_fault;
   assign op_rdata = st_ff.op_rdata;
   assign ar_done = st_ff.ar_done;
   assign ar_exc = st_ff.ar_exc;
   assign ar_operand = st_ff.ar_operand;
   assign ar_result = st_ff.ar_result;
   assign rounding_mode_field = st_ff.round;
   assign flush_tiny_results = st_ff.flush;
   assign subnormal_input_zeroing = st_ff.zero_in;
   assign exc_flags = st_ff.flags;
   assign exc_masks = st_ff.masks;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   sequence s_bad_load;
      op_valid && is_ld && ld_bad;
   endsequence

   sequence s_fault_no_change;
      op_done && op_fault && $stable(st_ff.masks) && $stable(st_ff.round);
   endsequence

   property p_rsv_fault;
      s_bad_load |=> s_fault_no_change;
   endproperty
   a_rsv_fault: assert property (p_rsv_fault)
      else $error("bad load did not fault");

   property p_rsv_zero;
      op_valid && op_kind == SFCS_OP_STORE |=> op_rdata[31:16] == 16'h0;
   endproperty
   a_rsv_zero: assert property (p_rsv_zero)
      else $error("reserved bits read nonzero");

   property p_zero_unsup;
      op_valid && is_ld && op_wdata[SFCS_ZERO_IN_BIT] && !ZERO_IN_SUPPORTED
         |=> op_fault && !subnormal_input_zeroing;
   endproperty
   a_zero_unsup: assert property (p_zero_unsup)
      else $error("bit 6 accepted without support");

   property p_sticky;
      !ld_ok |=> (exc_flags & $past(exc_flags)) == $past(exc_flags);
   endproperty
   a_sticky: assert property (p_sticky)
      else $error("flag dropped without load");

   property p_set_wins;
      ld_ok && ar_valid |=> (exc_flags & $past(set_flags)) == $past(set_flags);
   endproperty
   a_set_wins: assert property (p_set_wins)
      else $error("event lost under clear");

   property p_load_no_exc;
      op_valid && is_ld && !ar_valid |=> !ar_exc;
   endproperty
   a_load_no_exc: assert property (p_load_no_exc)
      else $error("load raised exception");

   property p_exc_cause;
      ar_exc |-> $past(ar_valid) && ar_done;
   endproperty
   a_exc_cause: assert property (p_exc_cause)
      else $error("exception without operation");

   property p_round_load;
      ld_ok |=> rounding_mode_field == $past(op_wdata[14:13]);
   endproperty
   a_round_load: assert property (p_round_load)
      else $error("rounding field not loaded");

   sequence s_masked_unf;
      ar_valid && ar_cond[SFCS_EX_UNF] && exc_masks[SFCS_EX_UNF] &&
         flush_tiny_results;
   endsequence

   property p_flush;
      s_masked_unf |=> ar_result[30:0] == 31'h0 &&
         ar_result[31] == $past(ar_res[31]) &&
         exc_flags[SFCS_EX_PRE] && exc_flags[SFCS_EX_UNF];
   endproperty
   a_flush: assert property (p_flush)
      else $error("tiny result not flushed");

   property p_flush_ignored;
      ar_valid && ar_cond[SFCS_EX_UNF] && !exc_masks[SFCS_EX_UNF]
         |=> ar_exc && ar_result == $past(ar_res);
   endproperty
   a_flush_ignored: assert property (p_flush_ignored)
      else $error("unmasked underflow mishandled");

   property p_zero_in_op;
      ar_valid && subnormal_input_zeroing && ar_src[30:23] == 8'h00
         |=> ar_operand[30:0] == 31'h0;
   endproperty
   a_zero_in_op: assert property (p_zero_in_op)
      else $error("subnormal operand not zeroed");

   property p_zero_in_flag;
      ar_valid && subnormal_input_zeroing && !ld_ok &&
         !exc_flags[SFCS_EX_DEN] |=> !exc_flags[SFCS_EX_DEN];
   endproperty
   a_zero_in_flag: assert property (p_zero_in_flag)
      else $error("subnormal flag set under zeroing");

   property p_align;
      op_valid && op_kind == SFCS_OP_PACKED_MEM && op_addr_lo != 4'h0
         |=> op_fault;
   endproperty
   a_align: assert property (p_align)
      else $error("misaligned packed access passed");

   property p_store;
      op_valid && op_kind == SFCS_OP_SAVE
         |=> op_done && op_rdata[15:0] == {$past(flush_tiny_results),
         $past(rounding_mode_field), $past(exc_masks),
         $past(subnormal_input_zeroing), $past(exc_flags)};
   endproperty
   a_store: assert property (p_store)
      else $error("saved word wrong");

   property p_mask_load;
      ld_ok |=> exc_masks == $past(op_wdata[12:7]);
   endproperty
   a_mask_load: assert property (p_mask_load)
      else $error("mask field not loaded");

   property p_mode_load;
      ld_ok |=> flush_tiny_results == $past(op_wdata[15]) &&
         subnormal_input_zeroing == $past(op_wdata[6]);
   endproperty
   a_mode_load: assert property (p_mode_load)
      else $error("mode bits not loaded");

   property p_flag_load;
      ld_ok && !ar_valid |=> exc_flags == $past(op_wdata[5:0]);
   endproperty
   a_flag_load: assert property (p_flag_load)
      else $error("flags not written by load");

   property p_op_answer;
      op_valid |=> op_done;
   endproperty
   a_op_answer: assert property (p_op_answer)
      else $error("request not answered");

   property p_op_quiet;
      !op_valid |=> !op_done && !op_fault;
   endproperty
   a_op_quiet: assert property (p_op_quiet)
      else $error("answer without request");

   property p_good_load;
      op_valid && is_ld && !ld_bad |=> !op_fault;
   endproperty
   a_good_load: assert property (p_good_load)
      else $error("clean load faulted");

   property p_never_fault;
      op_valid && op_kind inside {SFCS_OP_STORE, SFCS_OP_SAVE, SFCS_OP_UNALIGNED_MOVE,
         SFCS_OP_SCALAR_MEM} |=> !op_fault;
   endproperty
   a_never_fault: assert property (p_never_fault)
      else $error("exempt access faulted");

   property p_rdata_hold;
      !(op_valid && op_kind inside {SFCS_OP_STORE, SFCS_OP_SAVE})
         |=> $stable(op_rdata);
   endproperty
   a_rdata_hold: assert property (p_rdata_hold)
      else $error("stored word changed without store");

   property p_ar_quiet;
      !ar_valid |=> !ar_done && !ar_exc;
   endproperty
   a_ar_quiet: assert property (p_ar_quiet)
      else $error("exception without operation report");

   property p_exc_masked;
      ar_valid && !ftz && (ar_cond & ~exc_masks) == 6'h00
         |=> !ar_exc;
   endproperty
   a_exc_masked: assert property (p_exc_masked)
      else $error("masked condition raised exception");

   property p_no_flush;
      ar_valid && !flush_tiny_results |=> ar_result == $past(ar_res);
   endproperty
   a_no_flush: assert property (p_no_flush)
      else $error("result altered without flush mode");

   property p_no_zero_in;
      ar_valid && !subnormal_input_zeroing |=> ar_operand == $past(ar_src);
   endproperty
   a_no_zero_in: assert property (p_no_zero_in)
      else $error("operand altered without zeroing mode");

   property p_zero_in_exc;
      ar_valid && subnormal_input_zeroing && ar_cond == 6'h02 |=> !ar_exc;
   endproperty
   a_zero_in_exc: assert property (p_zero_in_exc)
      else $error("subnormal exception raised under zeroing");

endmodule : sfcs_top

// ### core/sfcs_pkg.sv
package sfcs_pkg;
   // field positions of the control/status word
   localparam int SFCS_FLAG_LSB = 0;
   localparam int SFCS_ZERO_IN_BIT = 6;
   localparam int SFCS_MASK_LSB = 7;
   localparam int SFCS_ROUND_LSB = 13;
   localparam int SFCS_FLUSH_BIT = 15;
   localparam int SFCS_RSV_LSB = 16;
   localparam int SFCS_RSV_MSB = 31;
   localparam int SFCS_NUM_EXC = 6;
   // exception order, same for flags and masks
   localparam int SFCS_EX_INV = 0;
   localparam int SFCS_EX_DEN = 1;
   localparam int SFCS_EX_DIV = 2;
   localparam int SFCS_EX_OVF = 3;
   localparam int SFCS_EX_UNF = 4;
   localparam int SFCS_EX_PRE = 5;
   // reset values
   localparam logic [5:0] SFCS_FLAGS_RST = 6'h00;
   localparam logic [5:0] SFCS_MASKS_RST = 6'h3f;
   localparam logic [1:0] SFCS_ROUND_RST = 2'h0;
   localparam logic SFCS_FLUSH_RST = 1'b0;
   localparam logic SFCS_ZERO_IN_RST = 1'b0;
   localparam logic [15:0] SFCS_RSV_RST = 16'h0000;
   // rounding field codes
   localparam logic [1:0] SFCS_ROUND_NEAR = 2'h0;
   localparam logic [1:0] SFCS_ROUND_DOWN = 2'h1;
   localparam logic [1:0] SFCS_ROUND_UP = 2'h2;
   localparam logic [1:0] SFCS_ROUND_ZERO = 2'h3;
   // memory operand sizes in bytes
   localparam int SFCS_PACKED_ALIGN = 16;
   localparam int SFCS_SCALAR_BYTES = 4;
   localparam logic [31:0] SFCS_SUPPORT_ALL = 32'h0000ffff;
   localparam logic [31:0] SFCS_SUPPORT_NO_ZERO_IN = 32'h0000ffbf;

   typedef enum logic [2:0] {
      SFCS_OP_LOAD,
      SFCS_OP_RESTORE,
      SFCS_OP_STORE,
      SFCS_OP_SAVE,
      SFCS_OP_PACKED_MEM,
      SFCS_OP_UNALIGNED_MOVE,
      SFCS_OP_SCALAR_MEM
   } sfcs_op_type;

   typedef struct packed {
      logic [5:0] flags;
      logic zero_in;
      logic [5:0] masks;
      logic [1:0] round;
      logic flush;
      logic op_done;
      logic op_fault;
      logic [31:0] op_rdata;
      logic ar_done;
      logic ar_exc;
      logic [31:0] ar_operand;
      logic [31:0] ar_result;
   } sfcs_state_type;
endpackage : sfcs_pkg

// ### tb/sfcs_tb_top.sv
`timescale 1ns/100ps
module sfcs_tb_top;
   import sfcs_pkg::*;
   typedef struct {
      sfcs_op_type k;
      logic [31:0] wd;
      logic [3:0] a;
      logic f;
      logic fnd;
      logic [31:0] rd;
   } sfcs_row_type;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic op_valid = 1'b0, ar_valid = 1'b0;
   sfcs_op_type op_kind = SFCS_OP_LOAD;
   logic [31:0] op_wdata = 32'h0, ar_src = 32'h0, ar_res = 32'h0;
   logic [3:0] op_addr_lo = 4'h0;
   logic [5:0] ar_cond = 6'h0;
   logic op_done, op_fault, ar_done, ar_exc, flush_tiny_results, subnormal_input_zeroing;
   logic fault_nd;
   logic [31:0] op_rdata, ar_operand, ar_result;
   logic [1:0] rounding_mode_field;
   logic [5:0] exc_flags, exc_masks;
   logic [1:0] rcs [4] = '{SFCS_ROUND_NEAR, SFCS_ROUND_DOWN, SFCS_ROUND_UP, SFCS_ROUND_ZERO};
   logic [5:0] m;
   int error_cnt = 0, samples_checked = 0, cyc = 0;
   sfcs_row_type rows [12] = '{
      '{SFCS_OP_LOAD, 32'h1f80, 4'h0, 1'b0, 1'b0, 32'h0},
      '{SFCS_OP_STORE, 32'h0, 4'h0, 1'b0, 1'b0, 32'h1f80},
      '{SFCS_OP_LOAD, 32'h00011f80, 4'h0, 1'b1, 1'b1, 32'h0},
      '{SFCS_OP_SAVE, 32'h0, 4'h0, 1'b0, 1'b0, 32'h1f80},
      '{SFCS_OP_RESTORE, 32'hffc0, 4'h0, 1'b0, 1'b1, 32'h0},
      '{SFCS_OP_STORE, 32'h0, 4'h0, 1'b0, 1'b0, 32'hffc0},
      '{SFCS_OP_RESTORE, 32'h80000000, 4'h0, 1'b1, 1'b1, 32'h0},
      '{SFCS_OP_SAVE, 32'h0, 4'h0, 1'b0, 1'b0, 32'hffc0},
      '{SFCS_OP_PACKED_MEM, 32'h0, 4'h8, 1'b1, 1'b1, 32'h0},
      '{SFCS_OP_PACKED_MEM, 32'h0, 4'h0, 1'b0, 1'b0, 32'h0},
      '{SFCS_OP_UNALIGNED_MOVE, 32'h0, 4'h4, 1'b0, 1'b0, 32'h0},
      '{SFCS_OP_SCALAR_MEM, 32'h0, 4'h2, 1'b0, 1'b0, 32'h0}};

   always #5 clk = ~clk;

   sfcs_top #(.ZERO_IN_SUPPORTED(1'b1)) dut_u (.clk(clk), .rst_n(rst_n), .op_valid(op_valid),
      .op_kind(op_kind), .op_wdata(op_wdata), .op_addr_lo(op_addr_lo), .op_done(op_done),
      .op_fault(op_fault), .op_rdata(op_rdata), .ar_valid(ar_valid), .ar_cond(ar_cond),
      .ar_src(ar_src), .ar_res(ar_res), .ar_done(ar_done), .ar_exc(ar_exc),
      .ar_operand(ar_operand), .ar_result(ar_result),
      .rounding_mode_field(rounding_mode_field), .flush_tiny_results(flush_tiny_results),
      .subnormal_input_zeroing(subnormal_input_zeroing), .exc_flags(exc_flags),
      .exc_masks(exc_masks));

   // same traffic into a part without subnormal zeroing support
   sfcs_top #(.ZERO_IN_SUPPORTED(1'b0)) dut_nd_u (.clk(clk), .rst_n(rst_n), .op_valid(op_valid),
      .op_kind(op_kind), .op_wdata(op_wdata), .op_addr_lo(op_addr_lo), .op_done(),
      .op_fault(fault_nd), .op_rdata(), .ar_valid(ar_valid), .ar_cond(ar_cond),
      .ar_src(ar_src), .ar_res(ar_res), .ar_done(), .ar_exc(), .ar_operand(), .ar_result(),
      .rounding_mode_field(), .flush_tiny_results(), .subnormal_input_zeroing(),
      .exc_flags(), .exc_masks());

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         error_cnt++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk

   task automatic end_sim();
      $display("checks %0d mismatches %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : end_sim

   task automatic do_op(input sfcs_op_type k, input logic [31:0] wd, input logic [3:0] a);
      @(posedge clk);
      op_valid <= 1'b1;
      op_kind <= k;
      op_wdata <= wd;
      op_addr_lo <= a;
      @(posedge clk);
      op_valid <= 1'b0;
      #1 chk(op_done, 1'b1);
   endtask : do_op

   task automatic do_ar(input logic [5:0] c, input logic [31:0] s, input logic [31:0] r);
      @(posedge clk);
      ar_valid <= 1'b1;
      ar_cond <= c;
      ar_src <= s;
      ar_res <= r;
      @(posedge clk);
      ar_valid <= 1'b0;
      #1 chk(ar_done, 1'b1);
   endtask : do_ar

   task automatic chk_rst();
      chk({exc_flags, exc_masks, rounding_mode_field, flush_tiny_results,
         subnormal_input_zeroing}, {6'h0, 6'h3f, 2'h0, 1'b0, 1'b0});
      do_op(SFCS_OP_STORE, 32'h0, 4'h0);
      chk(op_rdata, 32'h1f80);
   endtask : chk_rst

   always @(posedge clk) begin
      cyc++;
      if (cyc == 2000) begin
         error_cnt++;
         end_sim();
      end
   end

   initial begin
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      chk_rst();
      $display("test reset done");
      foreach (rows[i]) begin
         do_op(rows[i].k, rows[i].wd, rows[i].a);
         chk({fault_nd, op_fault}, {rows[i].fnd, rows[i].f});
         if (rows[i].k == SFCS_OP_STORE || rows[i].k == SFCS_OP_SAVE) begin
            chk(op_rdata, rows[i].rd);
         end
      end
      chk({flush_tiny_results, subnormal_input_zeroing}, 2'h3);
      $display("test table done");
      for (int i = 0; i < 4; i++) begin
         do_op(SFCS_OP_LOAD, {17'h0, 2'(i), 13'h1f80}, 4'h0);
         chk(rounding_mode_field, rcs[i]);
      end
      for (int i = 0; i < 6; i++) begin
         m = 6'h3f & ~(6'h1 << i);
         do_op(SFCS_OP_LOAD, {19'h0, m, 7'h0}, 4'h0);
         do_ar(6'h1 << i, 32'h3f800000, 32'h3f800000);
         chk({ar_exc, exc_flags}, {1'b1, 6'h1 << i});
         do_ar(6'h1 << ((i + 1) % 6), 32'h3f800000, 32'h3f800000);
         chk(ar_exc, 1'b0);
      end
      $display("test modes done");
      do_op(SFCS_OP_LOAD, 32'h3f, 4'h0);
      chk({op_fault, ar_exc}, 2'h0);
      repeat (2) @(posedge clk);
      #1 chk(ar_exc, 1'b0);
      do_ar(6'h0, 32'h3f800000, 32'h3f800000);
      chk({ar_exc, exc_flags}, {1'b0, 6'h3f});
      do_op(SFCS_OP_LOAD, 32'h9f80, 4'h0);
      do_ar(6'h10, 32'h3f800000, 32'h80000123);
      chk(ar_result, 32'h80000000);
      chk({ar_exc, exc_flags}, {1'b0, 6'h30});
      do_op(SFCS_OP_LOAD, 32'h9780, 4'h0);
      do_ar(6'h10, 32'h3f800000, 32'h80000123);
      chk({ar_exc, ar_result}, {1'b1, 32'h80000123});
      do_op(SFCS_OP_LOAD, 32'h1ec0, 4'h0);
      do_ar(6'h02, 32'h80000005, 32'h3f800000);
      chk(ar_operand, 32'h80000000);
      chk({ar_exc, exc_flags}, 7'h0);
      do_op(SFCS_OP_LOAD, 32'h1e80, 4'h0);
      do_ar(6'h02, 32'h00000007, 32'h3f800000);
      chk(ar_operand, 32'h7);
      chk({ar_exc, exc_flags}, {1'b1, 6'h02});
      $display("test arithmetic done");
      // clearing load and a detected overflow in the same cycle
      @(posedge clk);
      op_valid <= 1'b1;
      op_kind <= SFCS_OP_LOAD;
      op_wdata <= 32'h1f80;
      ar_valid <= 1'b1;
      ar_cond <= 6'h08;
      @(posedge clk);
      op_valid <= 1'b0;
      ar_valid <= 1'b0;
      #1 chk({ar_exc, exc_flags, exc_masks}, {1'b0, 6'h08, 6'h3f});
      do_op(SFCS_OP_STORE, 32'h0, 4'h0);
      chk(exc_flags, 6'h08);
      do_op(SFCS_OP_LOAD, 32'h1f80, 4'h0);
      chk(exc_flags, 6'h00);
      $display("test set wins done");
      @(posedge clk);
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      #1 chk_rst();
      $display("test second reset done");
      end_sim();
   end
endmodule : sfcs_tb_top
